// >>> rtl/sapi_inserter.v
`timescale 1ns/1ps
`include "sapi_defs.vh"

module sapi_inserter #(
    parameter LINE_W = 12,
    parameter SAMP_W = 13
)(
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire fmt_interlaced,
    input wire [LINE_W-1:0] fmt_lines,
    input wire [SAMP_W-1:0] fmt_samples,
    input wire in_valid,
    output wire in_ready,
    input wire [9:0] in_luma,
    input wire [9:0] in_chroma,
    input wire [LINE_W-1:0] in_line,
    input wire in_field2,
    input wire [SAMP_W-1:0] in_sample,
    input wire in_link_b,
    input wire in_stream2,
    input wire in_keep_luma,
    input wire in_keep_chroma,
    output wire out_valid,
    input wire out_ready,
    output wire [9:0] out_luma,
    output wire [9:0] out_chroma,
    output wire out_link_b,
    output wire out_stream2
);

// ------------------------------------------------------------
// Configuration registers
// ------------------------------------------------------------
reg [31:0] ctrl_reg;
reg [9:0] did_reg;
reg [9:0] sdid_reg;
reg [9:0] dc_reg;
reg [9:0] cs_reg;
reg [LINE_W-1:0] line1_reg;
reg [LINE_W-1:0] line2_reg;
reg [SAMP_W-1:0] offset_reg;
reg [9:0] udw_mem [0:`SAPI_UDW_WORDS-1];
reg armed_reg;
reg clearing_reg;
reg [7:0] clr_idx_reg;
reg range_bad_reg;
reg [15:0] pkt_cnt_reg;

wire [1:0] mode = ctrl_reg[`SAPI_CTRL_MODE_LSB+1:`SAPI_CTRL_MODE_LSB];
wire par_auto = ctrl_reg[`SAPI_CTRL_PAR_AUTO];
wire cs_auto = ctrl_reg[`SAPI_CTRL_CS_AUTO];
wire [1:0] field_sel = ctrl_reg[`SAPI_CTRL_FIELD_LSB+1:`SAPI_CTRL_FIELD_LSB];

// ------------------------------------------------------------
// AXI4-Lite write path
// ------------------------------------------------------------
wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
wire [11:0] waddr = {s_axi_awaddr[11:2], 2'b00};
wire wr_udw = waddr >= `SAPI_UDW_BASE &&
    waddr[9:2] < 8'hff;
wire [7:0] wr_idx = waddr[9:2];
wire wr_cmd = wr_go && waddr == `SAPI_CMD_ADDR && s_axi_wstrb[0];
reg wr_hit;

assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;

function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
        merge = (old & ~m) | (nw & m);
    end
endfunction

always @*
begin
    case (waddr)
        `SAPI_CTRL_ADDR, `SAPI_CMD_ADDR, `SAPI_DID_ADDR, `SAPI_SDID_ADDR,
        `SAPI_DC_ADDR, `SAPI_CS_ADDR, `SAPI_LINE1_ADDR, `SAPI_LINE2_ADDR,
        `SAPI_OFFSET_ADDR, `SAPI_STATUS_ADDR:
            wr_hit = 1'b1;
        default:
            wr_hit = wr_udw;
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        ctrl_reg <= `SAPI_CTRL_RESET;
        did_reg <= 10'h000;
        sdid_reg <= 10'h000;
        dc_reg <= 10'h000;
        cs_reg <= 10'h000;
        line1_reg <= {LINE_W{1'b0}};
        line2_reg <= {LINE_W{1'b0}};
        offset_reg <= {SAMP_W{1'b0}};
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SAPI_RESP_OKAY;
    end
    else
    begin
        if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `SAPI_RESP_OKAY : `SAPI_RESP_SLVERR;
            // Fields keep all ten bits in either parity mode
            case (waddr)
                `SAPI_CTRL_ADDR:
                    ctrl_reg <= merge(ctrl_reg, s_axi_wdata, wmask & 32'h000001ff);
                `SAPI_DID_ADDR:
                    did_reg <= (did_reg & ~wmask[9:0]) | (s_axi_wdata[9:0] & wmask[9:0]);
                `SAPI_SDID_ADDR:
                    sdid_reg <= (sdid_reg & ~wmask[9:0]) | (s_axi_wdata[9:0] & wmask[9:0]);
                `SAPI_DC_ADDR:
                    dc_reg <= (dc_reg & ~wmask[9:0]) | (s_axi_wdata[9:0] & wmask[9:0]);
                `SAPI_CS_ADDR:
                    cs_reg <= (cs_reg & ~wmask[9:0]) | (s_axi_wdata[9:0] & wmask[9:0]);
                `SAPI_LINE1_ADDR:
                    line1_reg <= (line1_reg & ~wmask[LINE_W-1:0]) |
                        (s_axi_wdata[LINE_W-1:0] & wmask[LINE_W-1:0]);
                `SAPI_LINE2_ADDR:
                    line2_reg <= (line2_reg & ~wmask[LINE_W-1:0]) |
                        (s_axi_wdata[LINE_W-1:0] & wmask[LINE_W-1:0]);
                `SAPI_OFFSET_ADDR:
                    offset_reg <= (offset_reg & ~wmask[SAMP_W-1:0]) |
                        (s_axi_wdata[SAMP_W-1:0] & wmask[SAMP_W-1:0]);
                default:
                    ;
            endcase
        end
    end
end

// ------------------------------------------------------------
// User word store and clear sweep
// ------------------------------------------------------------
// Sweep takes 255 cycles; bus writes to the store are dropped meanwhile
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        clearing_reg <= 1'b0;
        clr_idx_reg <= 8'h00;
    end
    else if (clearing_reg)
    begin
        clr_idx_reg <= clr_idx_reg + 8'h01;
        if (clr_idx_reg == 8'hfe)
            clearing_reg <= 1'b0;
    end
    else if (wr_cmd && s_axi_wdata[`SAPI_CMD_CLEAR_OK] &&
        !s_axi_wdata[`SAPI_CMD_CLEAR_CANCEL])
    begin
        clearing_reg <= 1'b1;
        clr_idx_reg <= 8'h00;
    end
end

always @(posedge aclk)
begin
    if (clearing_reg)
        udw_mem[clr_idx_reg] <= 10'h000;
    else if (wr_go && wr_udw && s_axi_wstrb[0] && s_axi_wstrb[1])
        udw_mem[wr_idx] <= s_axi_wdata[9:0];
end

// ------------------------------------------------------------
// AXI4-Lite read path
// ------------------------------------------------------------
wire [11:0] raddr = {s_axi_araddr[11:2], 2'b00};
wire rd_udw = raddr >= `SAPI_UDW_BASE && raddr[9:2] < 8'hff;
wire ins_busy;
reg [31:0] rd_val;
reg rd_hit;

assign s_axi_arready = !s_axi_rvalid;

always @*
begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (raddr)
        `SAPI_CTRL_ADDR: rd_val = ctrl_reg & 32'h000001ff;
        `SAPI_CMD_ADDR: rd_val = 32'h0;
        `SAPI_DID_ADDR: rd_val = {22'h0, did_reg};
        `SAPI_SDID_ADDR: rd_val = {22'h0, sdid_reg};
        `SAPI_DC_ADDR: rd_val = {22'h0, dc_reg};
        `SAPI_CS_ADDR: rd_val = {22'h0, cs_reg};
        `SAPI_LINE1_ADDR: rd_val = {{(32-LINE_W){1'b0}}, line1_reg};
        `SAPI_LINE2_ADDR: rd_val = {{(32-LINE_W){1'b0}}, line2_reg};
        `SAPI_OFFSET_ADDR: rd_val = {{(32-SAMP_W){1'b0}}, offset_reg};
        `SAPI_STATUS_ADDR:
            rd_val = {pkt_cnt_reg, 12'h0, range_bad_reg, ins_busy,
                clearing_reg, armed_reg};
        default:
        begin
            rd_hit = rd_udw;
            if (rd_udw)
                rd_val = {22'h0, udw_mem[raddr[9:2]]};
        end
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `SAPI_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `SAPI_RESP_OKAY : `SAPI_RESP_SLVERR;
    end
    else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

// ------------------------------------------------------------
// Packet word generation
// ------------------------------------------------------------
function [9:0] tx_word;
    input [9:0] w;
    input pa;
    begin
        if (pa)
            tx_word = {~(^w[7:0]), ^w[7:0], w[7:0]};
        else
            tx_word = w;
    end
endfunction

localparam ST_IDLE = 1'b0;
localparam ST_SEND = 1'b1;

reg state_reg;
reg [8:0] idx_reg;
reg [8:0] sum_reg;
reg [9:0] cur_word;
wire [9:0] dc_tx = tx_word(dc_reg, par_auto);
wire [8:0] last_idx = `SAPI_HDR_WORDS + {1'b0, dc_tx[7:0]};
wire [8:0] udw_off = idx_reg - `SAPI_HDR_WORDS;
wire [9:0] cs_calc = {~sum_reg[8], sum_reg};

assign ins_busy = state_reg == ST_SEND;

always @*
begin
    // Flags, header, payload, checksum in order
    case (idx_reg)
        9'h000: cur_word = `SAPI_ADF0;
        9'h001, 9'h002: cur_word = `SAPI_ADF1;
        9'h003: cur_word = tx_word(did_reg, par_auto);
        9'h004: cur_word = tx_word(sdid_reg, par_auto);
        9'h005: cur_word = dc_tx;
        default:
        begin
            if (idx_reg == last_idx)
                cur_word = cs_auto ? cs_calc : tx_word(cs_reg, par_auto);
            else
                cur_word = tx_word(udw_mem[udw_off[7:0]], par_auto);
        end
    endcase
end

// ------------------------------------------------------------
// Placement
// ------------------------------------------------------------
wire use_chroma = ctrl_reg[`SAPI_CTRL_CHROMA];
wire lane_ok = in_link_b == ctrl_reg[`SAPI_CTRL_LINK_B] &&
    in_stream2 == ctrl_reg[`SAPI_CTRL_STREAM2];
wire [LINE_W-1:0] want_line = (fmt_interlaced && in_field2) ? line2_reg : line1_reg;
wire field_ok = !fmt_interlaced ||
    (in_field2 ? field_sel[1] : field_sel[0]);
wire range_ok = want_line != {LINE_W{1'b0}} && want_line <= fmt_lines &&
    offset_reg < fmt_samples;
wire mode_ok = mode == `SAPI_MODE_CONT ||
    (mode == `SAPI_MODE_SINGLE && armed_reg);
wire buf_ready;
wire take = in_valid && buf_ready;
wire at_spot = lane_ok && field_ok && in_line == want_line &&
    in_sample == offset_reg;
wire start = take && state_reg == ST_IDLE && mode_ok && at_spot &&
    range_ok && !clearing_reg;
wire keep_here = use_chroma ? in_keep_chroma : in_keep_luma;
// Protected words stall the packet rather than drop a packet word
wire put = take && lane_ok && !keep_here &&
    (start || state_reg == ST_SEND);
wire done = put && idx_reg == last_idx;

assign in_ready = buf_ready;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        state_reg <= ST_IDLE;
        idx_reg <= 9'h000;
        sum_reg <= 9'h000;
        armed_reg <= 1'b0;
        range_bad_reg <= 1'b0;
        pkt_cnt_reg <= 16'h0000;
    end
    else
    begin
        range_bad_reg <= !range_ok;
        if (put)
        begin
            idx_reg <= idx_reg + 9'h001;
            if (idx_reg >= 9'h003 && idx_reg != last_idx)
                sum_reg <= sum_reg + cur_word[8:0];
        end
        case (state_reg)
            ST_IDLE:
                if (start)
                    state_reg <= ST_SEND;
            ST_SEND:
                if (done)
                begin
                    // Packet runs to its end even past the line end
                    state_reg <= ST_IDLE;
                    idx_reg <= 9'h000;
                    sum_reg <= 9'h000;
                    pkt_cnt_reg <= pkt_cnt_reg + 16'h0001;
                end
            default:
                state_reg <= ST_IDLE;
        endcase
        // Trigger during a packet rearms; the set wins over the start clear but not over the mode-off clear
        if (wr_cmd && s_axi_wdata[`SAPI_CMD_TRIGGER])
            armed_reg <= 1'b1;
        else if (start && mode == `SAPI_MODE_SINGLE)
            armed_reg <= 1'b0;
        if (mode == `SAPI_MODE_OFF && state_reg == ST_IDLE)
            armed_reg <= 1'b0;
    end
end

// ------------------------------------------------------------
// Two-entry output buffer
// ------------------------------------------------------------
wire [21:0] buf_in = {in_stream2, in_link_b,
    (put && use_chroma) ? cur_word : in_chroma,
    (put && !use_chroma) ? cur_word : in_luma};
reg [21:0] buf_mem [0:1];
reg [1:0] cnt_reg;
reg wp_reg;
reg rp_reg;
wire pop = out_valid && out_ready;

assign buf_ready = cnt_reg != 2'h2;
assign out_valid = cnt_reg != 2'h0;
assign out_luma = buf_mem[rp_reg][9:0];
assign out_chroma = buf_mem[rp_reg][19:10];
assign out_link_b = buf_mem[rp_reg][20];
assign out_stream2 = buf_mem[rp_reg][21];

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        cnt_reg <= 2'h0;
        wp_reg <= 1'b0;
        rp_reg <= 1'b0;
        buf_mem[0] <= 22'h0;
        buf_mem[1] <= 22'h0;
    end
    else
    begin
        if (take)
        begin
            buf_mem[wp_reg] <= buf_in;
            wp_reg <= ~wp_reg;
        end
        if (pop)
            rp_reg <= ~rp_reg;
        if (take && !pop)
            cnt_reg <= cnt_reg + 2'h1;
        else if (pop && !take)
            cnt_reg <= cnt_reg - 2'h1;
    end
end

endmodule // sapi_inserter

// >>> inc/sapi_defs.vh
`ifndef SAPI_DEFS_VH
`define SAPI_DEFS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define SAPI_CTRL_ADDR 12'h000
`define SAPI_CMD_ADDR 12'h004
`define SAPI_DID_ADDR 12'h008
`define SAPI_SDID_ADDR 12'h00c
`define SAPI_DC_ADDR 12'h010
`define SAPI_CS_ADDR 12'h014
`define SAPI_LINE1_ADDR 12'h018
`define SAPI_LINE2_ADDR 12'h01c
`define SAPI_OFFSET_ADDR 12'h020
`define SAPI_STATUS_ADDR 12'h024
`define SAPI_UDW_BASE 12'h400

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define SAPI_CTRL_MODE_LSB 0
`define SAPI_CTRL_PAR_AUTO 2
`define SAPI_CTRL_CS_AUTO 3
`define SAPI_CTRL_FIELD_LSB 4
`define SAPI_CTRL_CHROMA 6
`define SAPI_CTRL_LINK_B 7
`define SAPI_CTRL_STREAM2 8
`define SAPI_CTRL_RESET 32'h0000001c

`define SAPI_MODE_OFF 2'h0
`define SAPI_MODE_CONT 2'h1
`define SAPI_MODE_SINGLE 2'h2

`define SAPI_FIELD_1 2'h1
`define SAPI_FIELD_2 2'h2
`define SAPI_FIELD_BOTH 2'h3

// ------------------------------------------------------------
// Command bits
// ------------------------------------------------------------
`define SAPI_CMD_TRIGGER 0
`define SAPI_CMD_CLEAR_OK 1
`define SAPI_CMD_CLEAR_CANCEL 2

// ------------------------------------------------------------
// Packet framing
// ------------------------------------------------------------
`define SAPI_ADF0 10'h000
`define SAPI_ADF1 10'h3ff
`define SAPI_UDW_WORDS 255
`define SAPI_HDR_WORDS 9'h006

`define SAPI_RESP_OKAY 2'h0
`define SAPI_RESP_SLVERR 2'h2

`endif

// >>> test/sapi_inserter_sva.sv
`timescale 1ns/1ps
`include "sapi_defs.vh"
// ------------------------------
// Port checker
// ------------------------------
module sapi_inserter_sva #(
    parameter LINE_W = 12,
    parameter SAMP_W = 13
)(
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire in_valid,
    input wire in_ready,
    input wire [9:0] in_luma,
    input wire in_keep_luma,
    input wire in_link_b,
    input wire out_valid,
    input wire out_ready,
    input wire [9:0] out_luma,
    input wire [9:0] out_chroma,
    input wire out_link_b
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence s_in_take;
        in_valid && in_ready && !out_valid;
    endsequence
    a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
        else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_write_unmapped: assert property (s_wr_take ##0 s_axi_awaddr == 12'h7fc |=> s_axi_bresp == `SAPI_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
        else $error("read response dropped");
    a_keep_word: assert property (s_in_take ##0 in_keep_luma |=> out_valid && out_luma == $past(in_luma))
        else $error("protected word replaced");
    a_lane_follow: assert property (s_in_take |=> out_valid && out_link_b == $past(in_link_b))
        else $error("link flag not carried");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_luma) && $stable(out_chroma))
        else $error("stalled output changed");
    a_room_free: assert property (!out_valid |-> in_ready)
        else $error("empty buffer refuses");
endmodule // sapi_inserter_sva

bind sapi_inserter sapi_inserter_sva #(.LINE_W(LINE_W), .SAMP_W(SAMP_W)) u_sva (.*);

// >>> test/sapi_video_model.sv
`timescale 1ns/1ps
// ------------------------------
// Raster source and serializer sink
// ------------------------------
module sapi_video_model (
    input wire aclk,
    input wire aresetn,
    input wire go,
    input wire fmt_interlaced,
    input wire dual,
    input wire stall,
    input wire keep_on,
    input wire [4:0] keep_samp,
    output reg busy = 1'b0,
    output reg in_valid = 1'b0,
    input wire in_ready,
    output wire [9:0] in_luma,
    output wire [9:0] in_chroma,
    output wire [11:0] in_line,
    output wire in_field2,
    output wire [12:0] in_sample,
    output wire in_link_b,
    output wire in_keep_luma,
    output wire in_keep_chroma,
    output reg out_ready = 1'b0
);
    reg fld_reg = 1'b0;
    reg [11:0] line_reg = 12'h001;
    reg [12:0] samp_reg = 13'h0000;
    reg [1:0] tick_reg = 2'h0;
    wire [1:0] row = line_reg[1:0] - 2'h1;
    wire [7:0] idx = {fld_reg, row, samp_reg[4:0]};
    // Idle payload inverted so a late take cannot look right
    assign in_luma = in_valid ? {2'h1, idx} : ~{2'h1, idx};
    assign in_chroma = in_valid ? {2'h2, idx} : ~{2'h2, idx};
    assign in_line = line_reg;
    assign in_field2 = fld_reg;
    assign in_sample = samp_reg;
    assign in_link_b = dual & samp_reg[0];
    assign in_keep_luma = keep_on && samp_reg[4:0] == keep_samp;
    assign in_keep_chroma = in_keep_luma;
    always @(posedge aclk)
    begin
        tick_reg <= tick_reg + 2'h1;
        // Slow sink fills the buffer until it refuses
        out_ready <= !stall || tick_reg == 2'h0;
        if (!aresetn)
        begin
            busy <= 1'b0;
            in_valid <= 1'b0;
        end
        else if (go && !busy)
        begin
            busy <= 1'b1;
            in_valid <= 1'b1;
            fld_reg <= 1'b0;
            line_reg <= 12'h001;
            samp_reg <= 13'h0000;
        end
        else if (in_valid && in_ready)
        begin
            samp_reg <= samp_reg + 13'h0001;
            if (samp_reg == 13'h001f)
            begin
                samp_reg <= 13'h0000;
                line_reg <= line_reg + 12'h001;
                if (line_reg == 12'h004)
                begin
                    line_reg <= 12'h001;
                    fld_reg <= 1'b1;
                    in_valid <= fmt_interlaced && !fld_reg;
                    busy <= fmt_interlaced && !fld_reg;
                end
            end
        end
    end
endmodule // sapi_video_model

// >>> test/sdi_anc_packet_inserter_bench.sv
`timescale 1ns/1ps
`include "sapi_defs.vh"
module sdi_anc_packet_inserter_bench;
    // ------------------------------
    // Signals and instances
    // ------------------------------
    logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, fmt_interlaced = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, fmt_lines = 12'h004, in_line;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dual = 1'b0, stall = 1'b0;
    logic keep_on = 1'b0, in_stream2 = 1'b0;
    logic [4:0] keep_samp = 5'h09;
    logic [12:0] fmt_samples = 13'h0020, in_sample;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
    logic in_valid, in_ready, in_field2, in_link_b, in_keep_luma, in_keep_chroma;
    logic out_valid, out_ready, out_link_b, out_stream2;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [9:0] in_luma, in_chroma, out_luma, out_chroma;
    logic [9:0] cap_l [0:255];
    logic [9:0] cap_c [0:255];
    logic [9:0] pk [0:9];
    logic [9:0] u [0:2] = '{10'h3a5, 10'h012, 10'h1ff};
    int ocnt = 0, n_mismatch = 0, n_checks = 0;
    sapi_inserter dut (.*);
    sapi_video_model far_side (.*);
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        if (go)
            ocnt <= 0;
        else if (out_valid && out_ready)
        begin
            cap_l[ocnt] <= out_luma;
            cap_c[ocnt] <= out_chroma;
            ocnt <= ocnt + 1;
        end
    end
    // ------------------------------
    // Bus, stream and check tasks
    // ------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [9:0] vid(input int i, input logic c);
        return {c ? 2'h2 : 2'h1, i[7:0]};
    endfunction
    function automatic logic [9:0] par(input logic [9:0] x);
        return {~^x[7:0], ^x[7:0], x[7:0]};
    endfunction
    task automatic build(input logic ap, input logic ac);
        logic [8:0] s;
        s = 9'h000;
        pk = '{`SAPI_ADF0, `SAPI_ADF1, `SAPI_ADF1, 10'h2a1, 10'h1c4, 10'h103, u[0], u[1], u[2], 10'h155};
        for (int k = 3; k < 9; k++)
        begin
            if (ap)
                pk[k] = par(pk[k]);
            s = s + pk[k][8:0];
        end
        pk[9] = ac ? {~s[8], s} : (ap ? par(pk[9]) : pk[9]);
    endtask
    task automatic chk_pkt(input int pos, input int step, input logic ch, input int kp);
        for (int k = 0; k < 10; k++)
        begin
            if (pos == kp)
                pos += step;
            chk(ch ? cap_c[pos] : cap_l[pos], pk[k]);
            chk(ch ? cap_l[pos] : cap_c[pos], vid(pos, !ch));
            pos += step;
        end
        if (kp >= 0)
            chk(cap_c[kp], vid(kp, 1'b1));
    endtask
    task automatic chk_clean(input int n);
        for (int i = 0; i < n; i++)
        begin
            chk(cap_l[i], vid(i, 1'b0));
            chk(cap_c[i], vid(i, 1'b1));
        end
    endtask
    task automatic run(input logic il);
        @(posedge aclk);
        fmt_interlaced <= il;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(negedge aclk);
        while (busy !== 1'b0 || out_valid !== 1'b0) @(negedge aclk);
        chk(32'(ocnt), il ? 32'd256 : 32'd128);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge aclk);
        n_mismatch++;
        $display("wrong value at %0t: run hung", $time);
        end_sim;
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SAPI_CTRL_ADDR);
        chk(rv, `SAPI_CTRL_RESET);
        wr(12'h7fc, 32'h1);
        chk(resp, `SAPI_RESP_SLVERR);
        rd(12'h7fc);
        chk(resp, `SAPI_RESP_SLVERR);
        wr(`SAPI_DID_ADDR, 32'h2a1);
        wr(`SAPI_SDID_ADDR, 32'h1c4);
        wr(`SAPI_DC_ADDR, 32'h103);
        wr(`SAPI_CS_ADDR, 32'h155);
        wr(`SAPI_LINE1_ADDR, 32'h2);
        wr(`SAPI_LINE2_ADDR, 32'h3);
        wr(`SAPI_OFFSET_ADDR, 32'h5);
        rd(`SAPI_DID_ADDR);
        chk(rv, 32'h2a1);
        wr(12'h7f8, 32'h2aa);
        wr(`SAPI_CMD_ADDR, 32'h4);
        wr(`SAPI_CMD_ADDR, 32'h6);
        rd(12'h7f8);
        chk(rv, 32'h2aa);
        wr(`SAPI_CMD_ADDR, 32'h2);
        do rd(`SAPI_STATUS_ADDR); while (rv[1] !== 1'b0);
        rd(12'h7f8);
        chk(rv, 32'h0);
        for (int k = 0; k < 3; k++)
            wr(`SAPI_UDW_BASE + 12'(4 * k), {22'h0, u[k]});
        $display("test registers done");
        wr(`SAPI_CTRL_ADDR, 32'h5d);
        keep_on <= 1'b1;
        stall <= 1'b1;
        build(1'b1, 1'b1);
        run(1'b0);
        chk_pkt(37, 1, 1'b1, 41);
        rd(`SAPI_UDW_BASE);
        chk(rv, 32'h3a5);
        $display("test auto parity done");
        wr(`SAPI_CTRL_ADDR, 32'h11);
        keep_on <= 1'b0;
        build(1'b0, 1'b0);
        run(1'b0);
        chk_pkt(37, 1, 1'b0, -1);
        wr(`SAPI_OFFSET_ADDR, 32'h1c);
        run(1'b0);
        chk_pkt(60, 1, 1'b0, -1);
        $display("test manual packet done");
        wr(`SAPI_CTRL_ADDR, 32'h22);
        wr(`SAPI_OFFSET_ADDR, 32'h5);
        wr(`SAPI_CMD_ADDR, 32'h1);
        run(1'b1);
        chk_pkt(197, 1, 1'b0, -1);
        chk_clean(128);
        run(1'b1);
        chk_clean(256);
        $display("test single field done");
        wr(`SAPI_CTRL_ADDR, 32'h91);
        wr(`SAPI_OFFSET_ADDR, 32'h3);
        dual <= 1'b1;
        stall <= 1'b0;
        run(1'b0);
        chk_pkt(35, 2, 1'b0, -1);
        dual <= 1'b0;
        wr(`SAPI_LINE1_ADDR, 32'h5);
        run(1'b0);
        chk_clean(128);
        wr(`SAPI_LINE1_ADDR, 32'h2);
        wr(`SAPI_OFFSET_ADDR, 32'h20);
        run(1'b0);
        chk_clean(128);
        wr(`SAPI_OFFSET_ADDR, 32'h5);
        wr(`SAPI_CTRL_ADDR, 32'h10);
        run(1'b0);
        chk_clean(128);
        $display("test placement done");
        end_sim;
    end
endmodule // sdi_anc_packet_inserter_bench
